// ==== hw/ies_map.svh ====
`ifndef IES_MAP_SVH
`define IES_MAP_SVH

// Standard event latch bit positions
`define IES_EVL_OPC     0
`define IES_EVL_QUE     2
`define IES_EVL_DDE     3
`define IES_EVL_EXE     4
`define IES_EVL_CME     5
`define IES_EVL_PON     7

// Status byte bit positions
`define IES_SSB_QUES    3
`define IES_SSB_MAV     4
`define IES_SSB_ESB     5
`define IES_SSB_MSS     6
`define IES_SSB_OPER    7

// Reset values of the control state
`define IES_RST_MASK    8'h00
`define IES_RST_PSC     1'b1

// Reply placed in the response queue by the completion query
`define IES_ASCII_ONE   8'h31

// Slots of the nonvolatile mask store
`define IES_NV_EVM      2'h0
`define IES_NV_SVM      2'h1
`define IES_NV_PSC      2'h2

`endif

// ==== hw/ies_pkg.sv ====
`default_nettype none

package ies_pkg;

    // Commands taken from the command parser
    typedef enum logic [3:0] {
        CMD_CLS    = 4'h0,
        CMD_EVM_WR = 4'h1,
        CMD_EVM_RD = 4'h2,
        CMD_EVL_RD = 4'h3,
        CMD_OPC    = 4'h4,
        CMD_OPC_Q  = 4'h5,
        CMD_PSC_WR = 4'h6,
        CMD_PSC_RD = 4'h7,
        CMD_SVM_WR = 4'h8,
        CMD_SVM_RD = 4'h9,
        CMD_SSB_RD = 4'ha,
        CMD_WAI    = 4'hb
    } ies_cmd_t;

    // Command request with its argument
    typedef struct packed {
        logic       valid;      // Request present
        ies_cmd_t   code;       // Command
        logic [7:0] data;       // Write value
        logic       after_term; // Directly follows a message terminator
    } ies_req_t;

    // Error event pulses from the command and device logic
    typedef struct packed {
        logic cme;              // Command error
        logic exe;              // Execution error
        logic dde;              // Device-dependent error
        logic que;              // Query error
    } ies_evt_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_LOAD  = 2'h0,
        ST_IDLE  = 2'h1,
        ST_HOLDQ = 2'h2,
        ST_HOLDW = 2'h3
    } ies_state_t;

endpackage : ies_pkg

`default_nettype wire

// ==== hw/ies_nv_store.sv ====
`default_nettype none

`include "ies_map.svh"

// Nonvolatile store for the two enable masks and the power-on clear setting
module ies_nv_store (
    input  wire logic       ref_clk_i, // System clock
    input  wire logic       wr_en_i,   // Write strobe
    input  wire logic [1:0] wr_idx_i,  // Slot written
    input  wire logic [7:0] wr_data_i, // Value written
    output logic      [7:0] evm_o,     // Stored event mask
    output logic      [7:0] svm_o,     // Stored service mask
    output logic            psc_o      // Stored clear setting
);

    // Cells keep their content across reset; they model retained storage
    logic [7:0] mem_q [0:2] = '{8'h00, 8'h00, 8'h01};
    logic [7:0] nxt_word;              // Word after a write

    // Next content of the addressed cell
    always_comb
    begin
        nxt_word = wr_data_i;
    end

    // Store the cell on a write
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_idx_i] <= nxt_word;
        end
    end

    // Reads are combinational
    assign evm_o = mem_q[`IES_NV_EVM];
    assign svm_o = mem_q[`IES_NV_SVM];
    assign psc_o = mem_q[`IES_NV_PSC][0];

endmodule : ies_nv_store

`default_nettype wire

// ==== hw/ies_status.sv ====
`default_nettype none

`include "ies_map.svh"

//
// Functional notes
// - Clear-status zeroes event registers, status, errors
// - Clear after terminator also flushes response queue
// - Event mask gates events into event summary
// - Event latch layout; bits 6, 1 zero
// - Reading event latch returns then clears it
// - Completion command sets bit 0, no stall
// - Pending means an overlapped command or trigger still running
// - Completion query stalls, then returns ASCII one
// - Clear setting one zeroes masks at power-up
// - Clear setting zero saves and restores masks
// - Service mask gates status into bit 6
// - Serial poll clears request flag, not summary
// - Zero service mask never requests service
// - Status query leaves status byte unchanged
// - Message-available clears at reset, clear after terminator, empty
// - Poll shows request flag, query shows summary
// - Status byte layout; bits 2 to 0 zero
// - Wait command stalls; only device clear aborts
// - Questionable summary is masked OR of events
module ies_status (
    input  wire logic             ref_clk_i,       // System clock
    input  wire logic             rst_i,           // Sync reset, high
    input  wire ies_pkg::ies_req_t cmd_i,          // Command request
    output logic                  cmd_ready_o,     // Command may be taken
    input  wire ies_pkg::ies_evt_t evt_i,          // Error event pulses
    input  wire logic             oper_sum_i,      // Operation summary
    input  wire logic [15:0]      ques_event_i,    // Questionable events
    input  wire logic [15:0]      ques_enable_i,   // Questionable mask
    input  wire logic             busy_overlap_i,  // Overlapped command running
    input  wire logic             busy_trigger_i,  // Triggered action running
    input  wire logic             dev_clear_i,     // Bus device clear pulse
    input  wire logic             outq_nonempty_i, // Response queue has data
    input  wire logic             spoll_i,         // Serial poll pulse
    output logic                  rsp_valid_o,     // Reply byte strobe
    output logic      [7:0]       rsp_data_o,      // Reply byte
    output logic      [7:0]       spoll_data_o,    // Serial poll byte
    output logic                  srq_o,           // Service request
    output logic                  cls_o,           // Clear errors and chains
    output logic                  flush_o          // Flush response queue
);

    // Builds the status byte with bit 6 left open
    function automatic logic [7:0] ssb_base(input logic oper, input logic esb,
                                            input logic mav, input logic ques);
        logic [7:0] b;
        b = 8'h00;                      // Bits 2 to 0 stay zero
        b[`IES_SSB_OPER] = oper;
        b[`IES_SSB_ESB]  = esb;
        b[`IES_SSB_MAV]  = mav;
        b[`IES_SSB_QUES] = ques;
        return b;
    endfunction : ssb_base

    ies_pkg::ies_state_t state_ff;      // Sequencer state
    ies_pkg::ies_state_t nxt_state;
    logic [7:0] evl_ff;                 // Standard event latch
    logic [7:0] nxt_evl;
    logic [7:0] evm_ff;                 // Event enable mask
    logic [7:0] nxt_evm;
    logic [7:0] svm_ff;                 // Service enable mask
    logic [7:0] nxt_svm;
    logic       psc_ff;                 // Power-on clear setting
    logic       nxt_psc;
    logic       opc_arm_ff;             // Completion bit awaited
    logic       nxt_opc_arm;
    logic       mav_ff;                 // Message available
    logic       nxt_mav;
    logic       rqs_ff;                 // Request for service
    logic       nxt_rqs;
    logic       mss_prev_ff;            // Summary one cycle ago
    logic       ready_ff;
    logic       nxt_ready;
    logic       rsp_valid_ff;
    logic       nxt_rsp_valid;
    logic [7:0] rsp_data_ff;
    logic [7:0] nxt_rsp_data;
    logic [7:0] spoll_ff;
    logic [7:0] nxt_spoll;
    logic       srq_ff;
    logic       cls_ff;
    logic       nxt_cls;
    logic       flush_ff;
    logic       nxt_flush;
    logic       nv_wr;                  // Store write strobe
    logic [1:0] nv_idx;                 // Store slot
    logic [7:0] nv_data;                // Store value
    logic [7:0] nv_evm;                 // Stored event mask
    logic [7:0] nv_svm;                 // Stored service mask
    logic       nv_psc;                 // Stored clear setting
    logic       take;                   // Command taken this cycle
    logic       pend;                   // Operations still pending
    logic       esb;                    // Event summary
    logic       ques;                   // Questionable summary
    logic [7:0] base;                   // Status byte, bit 6 open
    logic       mss;                    // Master summary
    logic       mss_rise;               // Summary went high

    // Retained mask storage
    ies_nv_store u_nv (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (nv_wr),
        .wr_idx_i  (nv_idx),
        .wr_data_i (nv_data),
        .evm_o     (nv_evm),
        .svm_o     (nv_svm),
        .psc_o     (nv_psc)
    );

    // Summary terms of the status byte
    always_comb
    begin
        take     = cmd_i.valid && ready_ff;
        pend     = busy_overlap_i || busy_trigger_i;
        esb      = |(evl_ff & evm_ff);
        ques     = |(ques_event_i & ques_enable_i);
        base     = ssb_base(oper_sum_i, esb, mav_ff, ques);
        mss      = |(base & svm_ff);
        mss_rise = mss && !mss_prev_ff;
    end

    // Next values of the whole status state
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_evl       = evl_ff;
        nxt_evm       = evm_ff;
        nxt_svm       = svm_ff;
        nxt_psc       = psc_ff;
        nxt_opc_arm   = opc_arm_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp_data  = rsp_data_ff;
        nxt_cls       = 1'b0;
        nxt_flush     = 1'b0;
        nv_wr         = 1'b0;
        nv_idx        = `IES_NV_EVM;
        nv_data       = 8'h00;
        unique case (state_ff)
            // Power-up: restore or clear masks, note power-on
            ies_pkg::ST_LOAD:
            begin
                nxt_psc = nv_psc;
                nxt_evm = nv_psc ? `IES_RST_MASK : nv_evm;
                nxt_svm = nv_psc ? `IES_RST_MASK : nv_svm;
                nxt_evl[`IES_EVL_PON] = 1'b1;
                nxt_state = ies_pkg::ST_IDLE;
            end
            // Taking commands
            ies_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    unique case (cmd_i.code)
                        ies_pkg::CMD_CLS:
                        begin
                            nxt_evl = 8'h00;
                            nxt_cls = 1'b1;
                            nxt_flush = cmd_i.after_term;
                        end
                        ies_pkg::CMD_EVM_WR:
                        begin
                            nxt_evm = cmd_i.data;
                            nv_wr   = !psc_ff;
                            nv_idx  = `IES_NV_EVM;
                            nv_data = cmd_i.data;
                        end
                        ies_pkg::CMD_EVM_RD:
                        begin
                            nxt_rsp_valid = 1'b1;
                            nxt_rsp_data  = evm_ff;
                        end
                        ies_pkg::CMD_EVL_RD:
                        begin
                            nxt_rsp_valid = 1'b1;
                            nxt_rsp_data  = evl_ff;
                            nxt_evl       = 8'h00;
                        end
                        ies_pkg::CMD_OPC:
                        begin
                            nxt_opc_arm = 1'b1;
                        end
                        ies_pkg::CMD_OPC_Q:
                        begin
                            nxt_state = ies_pkg::ST_HOLDQ;
                        end
                        ies_pkg::CMD_PSC_WR:
                        begin
                            nxt_psc = cmd_i.data[0];
                            nv_wr   = 1'b1;
                            nv_idx  = `IES_NV_PSC;
                            nv_data = {7'h00, cmd_i.data[0]};
                        end
                        ies_pkg::CMD_PSC_RD:
                        begin
                            nxt_rsp_valid = 1'b1;
                            nxt_rsp_data  = {7'h00, psc_ff};
                        end
                        ies_pkg::CMD_SVM_WR:
                        begin
                            nxt_svm = cmd_i.data;
                            nv_wr   = !psc_ff;
                            nv_idx  = `IES_NV_SVM;
                            nv_data = cmd_i.data;
                        end
                        ies_pkg::CMD_SVM_RD:
                        begin
                            nxt_rsp_valid = 1'b1;
                            nxt_rsp_data  = svm_ff;
                        end
                        ies_pkg::CMD_SSB_RD:
                        begin
                            // Read only; summary shown at bit 6
                            nxt_rsp_valid = 1'b1;
                            nxt_rsp_data  = base | {1'b0, mss, 6'h00};
                        end
                        ies_pkg::CMD_WAI:
                        begin
                            nxt_state = ies_pkg::ST_HOLDW;
                        end
                        default:
                        begin
                            // Unknown codes are ignored
                            nxt_state = ies_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            // Completion query: hold commands, then reply
            ies_pkg::ST_HOLDQ:
            begin
                if (!pend)
                begin
                    nxt_rsp_valid = 1'b1;
                    nxt_rsp_data  = `IES_ASCII_ONE;
                    nxt_state     = ies_pkg::ST_IDLE;
                end
            end
            // Wait command: only completion or device clear ends it
            ies_pkg::ST_HOLDW:
            begin
                if (!pend || dev_clear_i)
                begin
                    nxt_state = ies_pkg::ST_IDLE;
                end
            end
        endcase
        // Completion bit once nothing is pending
        if (opc_arm_ff && !pend)
        begin
            nxt_evl[`IES_EVL_OPC] = 1'b1;
            nxt_opc_arm = 1'b0;
        end
        // New events win over any clear this cycle
        nxt_evl[`IES_EVL_CME] = nxt_evl[`IES_EVL_CME] | evt_i.cme;
        nxt_evl[`IES_EVL_EXE] = nxt_evl[`IES_EVL_EXE] | evt_i.exe;
        nxt_evl[`IES_EVL_DDE] = nxt_evl[`IES_EVL_DDE] | evt_i.dde;
        nxt_evl[`IES_EVL_QUE] = nxt_evl[`IES_EVL_QUE] | evt_i.que;
        nxt_ready = (nxt_state == ies_pkg::ST_IDLE);
        // Message available follows the queue, dropped by the flush
        nxt_mav = outq_nonempty_i && !nxt_flush;
        // Request flag: rise sets, poll clears, set wins
        nxt_rqs = (rqs_ff && !spoll_i) || mss_rise;
        if (svm_ff == 8'h00)
        begin
            nxt_rqs = 1'b0;
        end
        nxt_spoll = spoll_i ? (base | {1'b0, rqs_ff, 6'h00}) : spoll_ff;
    end

    // Registers of the status state
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_ff     <= ies_pkg::ST_LOAD;
            evl_ff       <= 8'h00;
            evm_ff       <= `IES_RST_MASK;
            svm_ff       <= `IES_RST_MASK;
            psc_ff       <= `IES_RST_PSC;
            opc_arm_ff   <= 1'b0;
            mav_ff       <= 1'b0;
            rqs_ff       <= 1'b0;
            mss_prev_ff  <= 1'b0;
            ready_ff     <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= 8'h00;
            spoll_ff     <= 8'h00;
            srq_ff       <= 1'b0;
            cls_ff       <= 1'b0;
            flush_ff     <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            evl_ff       <= nxt_evl;
            evm_ff       <= nxt_evm;
            svm_ff       <= nxt_svm;
            psc_ff       <= nxt_psc;
            opc_arm_ff   <= nxt_opc_arm;
            mav_ff       <= nxt_mav;
            rqs_ff       <= nxt_rqs;
            mss_prev_ff  <= mss;
            ready_ff     <= nxt_ready;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff  <= nxt_rsp_data;
            spoll_ff     <= nxt_spoll;
            srq_ff       <= nxt_rqs;
            cls_ff       <= nxt_cls;
            flush_ff     <= nxt_flush;
        end
    end

    assign cmd_ready_o  = ready_ff;
    assign rsp_valid_o  = rsp_valid_ff;
    assign rsp_data_o   = rsp_data_ff;
    assign spoll_data_o = spoll_ff;
    assign srq_o        = srq_ff;
    assign cls_o        = cls_ff;
    assign flush_o      = flush_ff;

    // Checks on the status logic
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    evl_rsvd_a: assert property (evl_ff[6] == 1'b0 && evl_ff[1] == 1'b0)
        else $error("reserved event bit set");
    cls_clear_a: assert property (take && cmd_i.code == ies_pkg::CMD_CLS && evt_i == '0
        |=> cls_o && evl_ff == 8'h00)
        else $error("clear-status did not clear");
    cls_flush_a: assert property (take && cmd_i.code == ies_pkg::CMD_CLS && cmd_i.after_term
        |=> flush_o && !mav_ff)
        else $error("flush or message bit wrong");
    evm_write_a: assert property (take && cmd_i.code == ies_pkg::CMD_EVM_WR
        |=> evm_ff == $past(cmd_i.data))
        else $error("event mask not written");
    evl_read_a: assert property (take && cmd_i.code == ies_pkg::CMD_EVL_RD
        |=> rsp_valid_o && rsp_data_o == $past(evl_ff))
        else $error("event latch read wrong");
    opc_bit_a: assert property (opc_arm_ff && !pend |=> evl_ff[`IES_EVL_OPC])
        else $error("completion bit missing");
    opcq_hold_a: assert property (take && cmd_i.code == ies_pkg::CMD_OPC_Q
        |=> !cmd_ready_o and (!pend |=> rsp_valid_o && rsp_data_o == `IES_ASCII_ONE))
        else $error("completion query reply wrong");
    psc_load_a: assert property (state_ff == ies_pkg::ST_LOAD && nv_psc
        |=> evm_ff == 8'h00 && svm_ff == 8'h00)
        else $error("masks not cleared at power-up");
    srq_zero_a: assert property (svm_ff == 8'h00 |=> !srq_o)
        else $error("service request with zero mask");
    poll_clear_a: assert property (spoll_i && !mss_rise |=> !rqs_ff)
        else $error("poll left request flag set");
    poll_data_a: assert property (spoll_i |=> spoll_data_o[6] == $past(rqs_ff))
        else $error("poll byte bit 6 wrong");
    srq_rise_a: assert property (mss_rise |=> srq_o)
        else $error("summary rise gave no request");
    wai_hold_a: assert property (state_ff == ies_pkg::ST_HOLDW && pend && !dev_clear_i
        |=> !cmd_ready_o)
        else $error("wait released early");

endmodule : ies_status

`default_nettype wire

// ==== bench/ies_host_model.sv ====
`default_nettype none

// Bus controller: serial polls the device once per service request
module ies_host_model (
    input  wire logic       ref_clk_i, // System clock
    input  wire logic       rst_i,     // Sync reset, high
    input  wire logic       srq_i,     // Service request line
    input  wire logic [3:0] dly_i,     // Cycles waited before the poll
    output logic            spoll_o    // Serial poll pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] wait_ff; // Cycles waited so far

    initial spoll_o = 1'b0;

    // Poll after a prompt or slow delay; one pulse, then restart the count from zero
    always @(negedge ref_clk_i)
    begin
        if (rst_i || spoll_o)
        begin
            spoll_o <= 1'b0;
            wait_ff <= 4'h0;
        end
        else if (srq_i && wait_ff == dly_i)
            spoll_o <= 1'b1;
        else if (srq_i)
            wait_ff <= wait_ff + 4'h1;
    end
endmodule : ies_host_model

`default_nettype wire

// ==== bench/ies_status_tb.sv ====
`default_nettype none

module ies_status_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic              ref_clk_i = 1'b0;  // Clock
    logic              rst_i     = 1'b1;  // Reset
    ies_pkg::ies_req_t cmd_i     = '0;    // Command
    ies_pkg::ies_evt_t evt_i     = '0;    // Error pulses
    logic              oper      = 1'b0;  // Operation summary
    logic [15:0]       qev       = 16'h0; // Questionable events
    logic [15:0]       qen       = 16'h0; // Questionable mask
    logic              bov       = 1'b0;  // Overlapped busy
    logic              btr       = 1'b0;  // Trigger busy
    logic              dcl       = 1'b0;  // Device clear
    logic              outq      = 1'b0;  // Response queue not empty
    logic [3:0]        dly       = 4'h0;  // Host poll delay
    logic              spoll, rdy, rv, srq, cls, flush;
    logic [7:0]        rd, sd, v;
    int                seed = 37, n_fail = 0, check_count = 0, i;

    always #10 ref_clk_i = ~ref_clk_i;

    ies_status dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .cmd_ready_o(rdy), .evt_i(evt_i),
        .oper_sum_i(oper), .ques_event_i(qev), .ques_enable_i(qen), .busy_overlap_i(bov),
        .busy_trigger_i(btr), .dev_clear_i(dcl), .outq_nonempty_i(outq), .spoll_i(spoll),
        .rsp_valid_o(rv), .rsp_data_o(rd), .spoll_data_o(sd), .srq_o(srq), .cls_o(cls), .flush_o(flush));

    ies_host_model host_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .srq_i(srq), .dly_i(dly), .spoll_o(spoll));

    // Expected status byte from its parts
    function automatic logic [7:0] ssb(input logic op, ms, es, mv, qs);
        return {op, ms, es, mv, qs, 3'h0};
    endfunction : ssb

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Hold a command from a falling edge until taken; returns one negedge after the take
    task automatic issue(input ies_pkg::ies_cmd_t c, input logic [7:0] d, input logic t);
        int k;
        @(negedge ref_clk_i);
        cmd_i = {1'b1, c, d, t};
        for (k = 0; k < 60 && rdy !== 1'b1; k++) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        cmd_i.valid = 1'b0;
    endtask : issue

    // Read command with its expected reply
    task automatic rdc(input ies_pkg::ies_cmd_t c, input logic [7:0] exp, input string nm);
        issue(c, 8'h00, 1'b0);
        chk({nm, " strobe"}, 8'h01, {7'h0, rv});
        chk(nm, exp, rd);
    endtask : rdc

    // One-cycle error pulse
    task automatic pulse(input logic [3:0] e);
        @(negedge ref_clk_i);
        evt_i = e;
        @(negedge ref_clk_i);
        evt_i = '0;
    endtask : pulse

    task automatic do_reset;
        rst_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        rst_i = 1'b0;
    endtask : do_reset

    // Print counts and verdict, then stop
    task automatic test_done;
        $display("Checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        test_done();
    end

    // Main sequence
    initial
    begin
        do_reset();
        rdc(ies_pkg::CMD_EVL_RD, 8'h80, "power-on latch");
        rdc(ies_pkg::CMD_EVL_RD, 8'h00, "latch after read");
        rdc(ies_pkg::CMD_EVM_RD, 8'h00, "event mask");
        rdc(ies_pkg::CMD_SVM_RD, 8'h00, "service mask");
        rdc(ies_pkg::CMD_PSC_RD, 8'h01, "clear setting");
        // Mask write and read back, all-ones event mask and all-zeros service mask first
        for (i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'hff : 8'($random(seed));
            issue(ies_pkg::CMD_EVM_WR, v, 1'b0);
            rdc(ies_pkg::CMD_EVM_RD, v, "event mask");
            issue(ies_pkg::CMD_SVM_WR, ~v, 1'b0);
            rdc(ies_pkg::CMD_SVM_RD, ~v, "service mask");
        end
        // Each error pulse lands on its own latch bit
        for (i = 0; i < 4; i++)
        begin
            pulse(4'h8 >> i);
            rdc(ies_pkg::CMD_EVL_RD, 8'h20 >> i, "event bit");
        end
        // Questionable and operation summaries; zero service mask never requests
        issue(ies_pkg::CMD_SVM_WR, 8'h00, 1'b0);
        for (i = 0; i < 4; i++)
        begin
            qev = (i == 3) ? 16'h0001 : 16'($random(seed));
            qen = (i == 3) ? 16'hffff : (i == 0) ? 16'h0 : 16'($random(seed));
            oper = i[0];
            repeat (2) @(negedge ref_clk_i);
            rdc(ies_pkg::CMD_SSB_RD, ssb(oper, 1'b0, 1'b0, 1'b0, |(qev & qen)), "status byte");
            chk("srq with zero mask", 8'h00, {7'h0, srq});
        end
        qev = 16'h0;
        oper = 1'b0;
        // Service request, polled promptly then slowly
        issue(ies_pkg::CMD_EVM_WR, 8'h20, 1'b0);
        issue(ies_pkg::CMD_SVM_WR, 8'h20, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            dly = (i == 0) ? 4'h0 : 4'h5;
            pulse(4'h8);
            for (int k = 0; k < 40 && spoll !== 1'b1; k++) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            chk("poll byte", ssb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0), sd);
            @(negedge ref_clk_i);
            chk("srq after poll", 8'h00, {7'h0, srq});
            rdc(ies_pkg::CMD_SSB_RD, ssb(1'b0, 1'b1, 1'b1, 1'b0, 1'b0), "status query");
            rdc(ies_pkg::CMD_EVL_RD, 8'h20, "latch");
            rdc(ies_pkg::CMD_SSB_RD, 8'h00, "status after latch read");
        end
        // Completion command waits for both busy sources without stalling
        bov = 1'b1;
        btr = 1'b1;
        issue(ies_pkg::CMD_OPC, 8'h00, 1'b0);
        chk("ready after completion command", 8'h01, {7'h0, rdy});
        bov = 1'b0;
        rdc(ies_pkg::CMD_EVL_RD, 8'h00, "latch while triggered");
        btr = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rdc(ies_pkg::CMD_EVL_RD, 8'h01, "completion bit");
        // Completion query holds commands, then replies
        btr = 1'b1;
        issue(ies_pkg::CMD_OPC_Q, 8'h00, 1'b0);
        repeat (3) @(negedge ref_clk_i);
        chk("ready in query hold", 8'h00, {7'h0, rdy});
        btr = 1'b0;
        for (i = 0; i < 20 && rv !== 1'b1; i++) @(negedge ref_clk_i);
        chk("completion reply", 8'h31, rd);
        // Wait command is aborted by device clear only
        bov = 1'b1;
        issue(ies_pkg::CMD_WAI, 8'h00, 1'b0);
        repeat (4) @(negedge ref_clk_i);
        chk("ready in wait", 8'h00, {7'h0, rdy});
        dcl = 1'b1;
        @(negedge ref_clk_i);
        dcl = 1'b0;
        @(negedge ref_clk_i);
        chk("ready after device clear", 8'h01, {7'h0, rdy});
        bov = 1'b0;
        // Clear status, after a terminator and not
        issue(ies_pkg::CMD_SVM_WR, 8'h00, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            outq = 1'b1;
            pulse(4'h8);
            rdc(ies_pkg::CMD_SSB_RD, ssb(1'b0, 1'b0, 1'b1, 1'b1, 1'b0), "status byte");
            issue(ies_pkg::CMD_CLS, 8'h00, i == 0);
            chk("clear pulse", 8'h01, {7'h0, cls});
            chk("flush pulse", (i == 0) ? 8'h01 : 8'h00, {7'h0, flush});
            outq = 1'b0;
            repeat (2) @(negedge ref_clk_i);
            rdc(ies_pkg::CMD_SSB_RD, 8'h00, "status after clear");
            rdc(ies_pkg::CMD_EVL_RD, 8'h00, "latch after clear");
        end
        // Setting zero keeps masks over power-up, setting one clears them
        v = 8'($random(seed));
        issue(ies_pkg::CMD_PSC_WR, 8'h00, 1'b0);
        issue(ies_pkg::CMD_EVM_WR, v, 1'b0);
        issue(ies_pkg::CMD_SVM_WR, 8'h5a, 1'b0);
        do_reset();
        rdc(ies_pkg::CMD_EVM_RD, v, "restored event mask");
        rdc(ies_pkg::CMD_SVM_RD, 8'h5a, "restored service mask");
        rdc(ies_pkg::CMD_PSC_RD, 8'h00, "clear setting");
        issue(ies_pkg::CMD_PSC_WR, 8'h01, 1'b0);
        do_reset();
        rdc(ies_pkg::CMD_EVM_RD, 8'h00, "cleared event mask");
        rdc(ies_pkg::CMD_SVM_RD, 8'h00, "cleared service mask");
        test_done();
    end
endmodule : ies_status_tb

`default_nettype wire
